// File: src/aci_pkg.sv
package aci_pkg;
  // function select values for the five control registers
  localparam logic [7:0] FSEL_LEFT = 8'h00;
  localparam logic [7:0] FSEL_RIGHT = 8'h01;
  localparam logic [7:0] FSEL_LOW = 8'h02;
  localparam logic [7:0] FSEL_HIGH = 8'h03;
  localparam logic [7:0] FSEL_SWITCH = 8'h08;
  // switch word field positions
  localparam int SW_SILENCE = 5;
  localparam int SW_EFF_EN = 4;
  localparam int SW_EFF_KIND = 3;
  localparam int SW_ROUTE_HI = 2;
  localparam int SW_ROUTE_LO = 1;
  localparam int SW_SOURCE = 0;
  // gain and tone code fields
  localparam int GAIN_MSB = 5;
  localparam int TONE_MSB = 3;
  // values after reset
  localparam logic [5:0] RST_GAIN = 6'h00;
  localparam logic [3:0] RST_TONE = 4'h6;
  localparam logic [5:0] RST_SWITCH = 6'h26;
  localparam logic [7:0] RST_FSEL = 8'h00;
  // decode constants
  localparam logic [5:0] VOL_MIN_CODE = 6'h1C;
  localparam int VOL_OFFSET_DB = 120;
  localparam int VOL_STEP_DB = 2;
  localparam int TONE_STEP_DB = 3;
  localparam logic [3:0] TONE_FLAT = 4'h6;
  localparam logic [3:0] TONE_MIN = 4'h2;
  localparam logic [3:0] BASS_MAX = 4'hB;
  localparam logic [3:0] TREBLE_MAX = 4'hA;
  // bit counter: data bits 0..7, acknowledge slot at 8
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // own write address, value is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h41;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_SUB = 5'h04,
    ST_DATA = 5'h08,
    ST_SKIP = 5'h10
  } aci_state_t;

  typedef enum logic [1:0] {
    ROUTE_STEREO = 2'h0,
    ROUTE_SOUND_A = 2'h1,
    ROUTE_SOUND_B = 2'h2
  } aci_route_t;

  typedef enum logic [1:0] {
    EFF_MONO = 2'h0,
    EFF_PSEUDO = 2'h1,
    EFF_SPATIAL = 2'h2,
    EFF_LINEAR = 2'h3
  } aci_effect_t;
endpackage

// File: src/aci_i2c_receiver.sv
`timescale 1ns/1ns
// Function
// - SDA falling while SCL high means start
// - SDA rising while SCL high means stop
// - start resets byte and protocol state
// - bus busy from start until stop
// - second byte stored as function select
// - function select advances after each data byte
// - data byte goes to selected register
// - volume code gives 2 dB steps, low codes mute
// - left and right volume fully independent
// - bass 3 dB steps, saturating +15/-12 dB
// - treble 3 dB steps, saturating +12/-12 dB
// - switch word layout, silence down to source
// - source pick chooses input pair one or two
// - route bits choose stereo, sound A, sound B
// - effect bits choose spatial, pseudo, linear, forced mono
// - forced mono never allows pseudo stereo
// - reset sets silence; writes clear or set it
module aci_i2c_receiver (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sclClk,
  input wire logic sdaIn,
  output logic sdaOutFf,
  output logic sdaOeFf,
  output logic busyFf,
  output logic [5:0] leftGainCodeFf,
  output logic [5:0] rightGainCodeFf,
  output logic [3:0] lowToneCodeFf,
  output logic [3:0] highToneCodeFf,
  output logic silenceFlagFf,
  output logic effectEnableFf,
  output logic effectKindFf,
  output logic outputRouteHighFf,
  output logic outputRouteLowFf,
  output logic inputSourcePickFf,
  output logic signed [7:0] leftGainDbFf,
  output logic leftFullAttFf,
  output logic signed [7:0] rightGainDbFf,
  output logic rightFullAttFf,
  output logic signed [7:0] lowToneDbFf,
  output logic signed [7:0] highToneDbFf,
  output logic inputPairTwoFf,
  output aci_pkg::aci_route_t routeModeFf,
  output aci_pkg::aci_effect_t effectModeFf,
  output logic pseudoOnFf
);
  import aci_pkg::*;

  // volume code to gain in dB; codes below the floor are full attenuation
  function automatic logic signed [7:0] volDb(input logic [5:0] code);
    int v;
    v = VOL_STEP_DB * int'(code) - VOL_OFFSET_DB;
    if (code < VOL_MIN_CODE) begin
      v = 0;
    end
    return 8'(v);
  endfunction

  // tone code to gain in dB, clamped at both ends
  function automatic logic signed [7:0] toneDb(input logic [3:0] code, input logic [3:0] maxCode);
    logic [3:0] c;
    c = code;
    if (c < TONE_MIN) begin
      c = TONE_MIN;
    end
    if (c > maxCode) begin
      c = maxCode;
    end
    return 8'(TONE_STEP_DB * (int'(c) - int'(TONE_FLAT)));
  endfunction

  logic [7:0] linkShiftFf;
  logic [1:0] sclSyncFf;
  logic [1:0] sdaSyncFf;
  logic sclDlyFf;
  logic sdaDlyFf;
  aci_state_t stateFf;
  aci_state_t nxt_state;
  logic [3:0] bitCntFf;
  logic [7:0] fselFf;
  logic ackPendFf;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic byteDone;
  logic wrEn;
  logic addrHit;
  logic [7:0] rxByte;

  // link side: SDA is sampled on the bus clock itself, during the stable high phase
  always_ff @(posedge sclClk or negedge rst_n) begin
    if (!rst_n) begin
      linkShiftFf <= 8'h00;
    end else begin
      linkShiftFf <= {linkShiftFf[6:0], sdaIn};
    end
  end

  // two-flop synchronisers for the pins, then one delay stage for edge detection
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclSyncFf <= 2'h3;
      sdaSyncFf <= 2'h3;
      sclDlyFf <= 1'b1;
      sdaDlyFf <= 1'b1;
    end else begin
      sclSyncFf <= {sclSyncFf[0], sclClk};
      sdaSyncFf <= {sdaSyncFf[0], sdaIn};
      sclDlyFf <= sclSyncFf[1];
      sdaDlyFf <= sdaSyncFf[1];
    end
  end

  // bus events seen in the system domain
  assign sclRise = sclSyncFf[1] & ~sclDlyFf;
  assign sclFall = ~sclSyncFf[1] & sclDlyFf;
  assign startSeen = sclSyncFf[1] & sclDlyFf & sdaDlyFf & ~sdaSyncFf[1];
  assign stopSeen = sclSyncFf[1] & sclDlyFf & ~sdaDlyFf & sdaSyncFf[1];

  // the link shift word is read two cycles after its clock edge, when it is settled and
  // stays so until the next rise (at least the SCL high plus low time)
  assign rxByte = linkShiftFf;
  assign byteDone = sclRise & (bitCntFf == BIT_LAST_DATA) & (stateFf != ST_IDLE);
  assign addrHit = (rxByte[7:1] == DEV_ADDR) & ~rxByte[0];
  assign wrEn = byteDone & (stateFf == ST_DATA);

  // protocol state; start overrides everything, even mid byte
  always_comb begin
    nxt_state = stateFf;
    if (startSeen) begin
      nxt_state = ST_ADDR;
    end else if (stopSeen) begin
      nxt_state = ST_IDLE;
    end else if (byteDone) begin
      case (stateFf)
        ST_ADDR: begin
          nxt_state = addrHit ? ST_SUB : ST_SKIP;
        end
        ST_SUB: begin
          nxt_state = ST_DATA;
        end
        ST_DATA: begin
          nxt_state = ST_DATA;
        end
        ST_SKIP: begin
          nxt_state = ST_SKIP;
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stateFf <= ST_IDLE;
    end else begin
      stateFf <= nxt_state;
    end
  end

  // busy flag follows start and stop
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busyFf <= 1'b0;
    end else if (startSeen) begin
      busyFf <= 1'b1;
    end else if (stopSeen) begin
      busyFf <= 1'b0;
    end
  end

  // bit counter over eight data bits and the acknowledge slot
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bitCntFf <= 4'h0;
    end else if (startSeen || stopSeen) begin
      bitCntFf <= 4'h0;
    end else if (sclRise && stateFf != ST_IDLE) begin
      bitCntFf <= (bitCntFf == BIT_ACK) ? 4'h0 : bitCntFf + 4'h1;
    end
  end

  // acknowledge: pend at the eighth rise, drive low from the next fall to the one after
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ackPendFf <= 1'b0;
      sdaOeFf <= 1'b0;
    end else if (startSeen || stopSeen) begin
      ackPendFf <= 1'b0;
      sdaOeFf <= 1'b0;
    end else begin
      if (byteDone && (stateFf != ST_SKIP) && (stateFf != ST_ADDR || addrHit)) begin
        ackPendFf <= 1'b1;
      end else if (sclFall && ackPendFf) begin
        ackPendFf <= 1'b0;
      end
      if (sclFall && ackPendFf) begin
        sdaOeFf <= 1'b1;
      end else if (sclFall && sdaOeFf) begin
        sdaOeFf <= 1'b0;
      end
    end
  end

  // the pin is open drain: only ever driven low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdaOutFf <= 1'b0;
    end else begin
      sdaOutFf <= 1'b0;
    end
  end

  // function select: loaded by the second byte, stepped after every data byte
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fselFf <= RST_FSEL;
    end else if (byteDone && stateFf == ST_SUB) begin
      fselFf <= rxByte;
    end else if (wrEn) begin
      fselFf <= fselFf + 8'h01;
    end
  end

  // volume registers, each written on its own select only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      leftGainCodeFf <= RST_GAIN;
      rightGainCodeFf <= RST_GAIN;
    end else if (wrEn) begin
      if (fselFf == FSEL_LEFT) begin
        leftGainCodeFf <= rxByte[GAIN_MSB:0];
      end
      if (fselFf == FSEL_RIGHT) begin
        rightGainCodeFf <= rxByte[GAIN_MSB:0];
      end
    end
  end

  // tone registers; the padding ones above the code are not stored
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowToneCodeFf <= RST_TONE;
      highToneCodeFf <= RST_TONE;
    end else if (wrEn) begin
      if (fselFf == FSEL_LOW) begin
        lowToneCodeFf <= rxByte[TONE_MSB:0];
      end
      if (fselFf == FSEL_HIGH) begin
        highToneCodeFf <= rxByte[TONE_MSB:0];
      end
    end
  end

  // switch word; silence comes up set so the outputs stay quiet until configured
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      silenceFlagFf <= RST_SWITCH[SW_SILENCE];
      effectEnableFf <= RST_SWITCH[SW_EFF_EN];
      effectKindFf <= RST_SWITCH[SW_EFF_KIND];
      outputRouteHighFf <= RST_SWITCH[SW_ROUTE_HI];
      outputRouteLowFf <= RST_SWITCH[SW_ROUTE_LO];
      inputSourcePickFf <= RST_SWITCH[SW_SOURCE];
    end else if (wrEn && fselFf == FSEL_SWITCH) begin
      silenceFlagFf <= rxByte[SW_SILENCE];
      effectEnableFf <= rxByte[SW_EFF_EN];
      effectKindFf <= rxByte[SW_EFF_KIND];
      outputRouteHighFf <= rxByte[SW_ROUTE_HI];
      outputRouteLowFf <= rxByte[SW_ROUTE_LO];
      inputSourcePickFf <= rxByte[SW_SOURCE];
    end
  end

  // gain decode, one cycle behind the code registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      leftGainDbFf <= 8'sh00;
      rightGainDbFf <= 8'sh00;
      leftFullAttFf <= 1'b1;
      rightFullAttFf <= 1'b1;
    end else begin
      leftGainDbFf <= volDb(leftGainCodeFf);
      rightGainDbFf <= volDb(rightGainCodeFf);
      leftFullAttFf <= leftGainCodeFf < VOL_MIN_CODE;
      rightFullAttFf <= rightGainCodeFf < VOL_MIN_CODE;
    end
  end

  // tone decode with saturation at the end codes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowToneDbFf <= 8'sh00;
      highToneDbFf <= 8'sh00;
    end else begin
      lowToneDbFf <= toneDb(lowToneCodeFf, BASS_MAX);
      highToneDbFf <= toneDb(highToneCodeFf, TREBLE_MAX);
    end
  end

  // source, route and effect decode; route 11 is undefined and falls back to stereo
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      inputPairTwoFf <= 1'b0;
      routeModeFf <= ROUTE_STEREO;
      effectModeFf <= EFF_MONO;
      pseudoOnFf <= 1'b0;
    end else begin
      inputPairTwoFf <= inputSourcePickFf;
      case ({outputRouteHighFf, outputRouteLowFf})
        2'h1: begin
          routeModeFf <= ROUTE_SOUND_A;
        end
        2'h2: begin
          routeModeFf <= ROUTE_SOUND_B;
        end
        default: begin
          routeModeFf <= ROUTE_STEREO;
        end
      endcase
      case ({effectKindFf, effectEnableFf})
        2'h3: begin
          effectModeFf <= EFF_SPATIAL;
        end
        2'h1: begin
          effectModeFf <= EFF_PSEUDO;
        end
        2'h0: begin
          effectModeFf <= EFF_MONO;
        end
        default: begin
          effectModeFf <= EFF_LINEAR;
        end
      endcase
      pseudoOnFf <= effectEnableFf & ~effectKindFf;
    end
  end
endmodule

// File: testbench/aci_i2c_receiver_sva.sv
`timescale 1ns/1ns
module aci_i2c_receiver_sva import aci_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sclClk,
  input wire logic sdaIn,
  input wire logic sdaOutFf,
  input wire logic sdaOeFf,
  input wire logic busyFf,
  input wire logic [5:0] leftGainCodeFf,
  input wire logic [5:0] rightGainCodeFf,
  input wire logic [3:0] lowToneCodeFf,
  input wire logic [3:0] highToneCodeFf,
  input wire logic effectEnableFf,
  input wire logic effectKindFf,
  input wire logic outputRouteHighFf,
  input wire logic outputRouteLowFf,
  input wire logic inputSourcePickFf,
  input wire logic signed [7:0] leftGainDbFf,
  input wire logic leftFullAttFf,
  input wire logic signed [7:0] rightGainDbFf,
  input wire logic rightFullAttFf,
  input wire logic silenceFlagFf,
  input wire logic signed [7:0] lowToneDbFf,
  input wire logic signed [7:0] highToneDbFf,
  input wire logic inputPairTwoFf,
  input wire aci_pkg::aci_route_t routeModeFf,
  input wire aci_pkg::aci_effect_t effectModeFf,
  input wire logic pseudoOnFf
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // clamp first, so out-of-range codes saturate instead of wrapping
  function automatic logic [7:0] toneDb(input logic [3:0] c, input logic [3:0] mx);
    logic [3:0] k;
    k = (c < 4'h2) ? 4'h2 : (c > mx) ? mx : c;
    return {4'h0, k} * 8'h03 - 8'h12;
  endfunction
  a_start_busy: assert property ($fell(sdaIn) && sclClk |-> ##[2:4] busyFf)
    else $error("start not seen");
  a_stop_free: assert property ($rose(sdaIn) && sclClk |-> ##[2:4] !busyFf)
    else $error("stop not seen");
  a_ack_slot: assert property ($rose(sdaOeFf) |-> !sclClk && busyFf && !sdaOutFf)
    else $error("ack outside slot");
  a_ack_release: assert property ($fell(sclClk) && sdaOeFf |-> ##[1:5] !sdaOeFf)
    else $error("ack not released");
  a_source_pick: assert property (inputPairTwoFf == $past(inputSourcePickFf))
    else $error("source decode");
  a_route_mode: assert property (routeModeFf == ((!$past(outputRouteHighFf) && $past(outputRouteLowFf)) ?
    ROUTE_SOUND_A : ($past(outputRouteHighFf) && !$past(outputRouteLowFf)) ? ROUTE_SOUND_B : ROUTE_STEREO))
    else $error("route decode");
  a_effect_mode: assert property (effectModeFf == ($past(effectEnableFf) ? ($past(effectKindFf) ? EFF_SPATIAL :
    EFF_PSEUDO) : ($past(effectKindFf) ? EFF_LINEAR : EFF_MONO)))
    else $error("effect decode");
  // pseudo must agree with the decoded effect, so it can never show up beside forced mono
  a_mono_no_pseudo: assert property (pseudoOnFf == $past(effectEnableFf && !effectKindFf) &&
    !(pseudoOnFf && effectModeFf != EFF_PSEUDO))
    else $error("pseudo in mono");
  // mute only moves while a transfer is open, never by itself
  a_silence_hold: assert property (!busyFf && $past(!busyFf) |-> $stable(silenceFlagFf))
    else $error("silence changed outside transfer");
  a_left_gain: assert property (leftGainDbFf == ($past(leftGainCodeFf) < 6'h1C ? 8'h00 :
    {1'b0, $past(leftGainCodeFf), 1'b0} - 8'h78) && leftFullAttFf == ($past(leftGainCodeFf) < 6'h1C))
    else $error("left gain decode");
  a_right_gain: assert property (rightGainDbFf == ($past(rightGainCodeFf) < 6'h1C ? 8'h00 :
    {1'b0, $past(rightGainCodeFf), 1'b0} - 8'h78) &&
    rightFullAttFf == ($past(rightGainCodeFf) < 6'h1C))
    else $error("right gain decode");
  a_bass_gain: assert property (lowToneDbFf == toneDb($past(lowToneCodeFf), 4'hB))
    else $error("bass decode");
  a_treble_gain: assert property (highToneDbFf == toneDb($past(highToneCodeFf), 4'hA))
    else $error("treble decode");
endmodule
bind aci_i2c_receiver aci_i2c_receiver_sva chk (.*);

// File: testbench/aci_bus_master.sv
`timescale 1ns/1ns
module aci_bus_master (
  output logic sclClk,
  output logic sdaDrv,
  input wire logic sdaWire
);
  logic linkClk = 1'b0;
  // 15 ns link tick; scl phases of 8 ticks stay above 5 system clocks
  always begin
    #7 linkClk = 1'b1;
    #8 linkClk = 1'b0;
  end
  initial begin
    sclClk = 1'b1;
    sdaDrv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge linkClk);
  endtask
  // also a repeated start from scl low; clock stands high outside frames
  task automatic startCond();
    tick(1);
    sdaDrv <= 1'b1;
    tick(7);
    sclClk <= 1'b1;
    tick(8);
    sdaDrv <= 1'b0;
    tick(8);
    sclClk <= 1'b0;
  endtask
  task automatic stopCond();
    tick(1);
    sdaDrv <= 1'b0;
    tick(7);
    sclClk <= 1'b1;
    tick(8);
    sdaDrv <= 1'b1;
    tick(8);
  endtask
  // msb first, data changes only while scl is low
  task automatic bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      tick(1);
      sdaDrv <= b[i];
      tick(7);
      sclClk <= 1'b1;
      tick(8);
      sclClk <= 1'b0;
    end
  endtask
  task automatic sendByte(input logic [7:0] b, output logic ack);
    bits(b, 8);
    tick(1);
    sdaDrv <= 1'b1;
    tick(7);
    sclClk <= 1'b1;
    tick(4);
    ack = !sdaWire;
    tick(4);
    sclClk <= 1'b0;
  endtask
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import aci_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sclClk, sdaDrv, sdaIn, sdaOutFf, sdaOeFf, busyFf, silence, effEn, effKind, routeHi, routeLo, srcPick;
  logic [5:0] leftCode, rightCode;
  logic [3:0] lowCode, highCode;
  logic [7:0] mdl [0:8];
  int failures = 0;
  int samplesChecked = 0;
  always #10 sys_clk = ~sys_clk;
  // open-drain wire with pull-up: low if either party pulls
  assign sdaIn = sdaDrv && !(sdaOeFf && !sdaOutFf);
  aci_bus_master M (.sclClk(sclClk), .sdaDrv(sdaDrv), .sdaWire(sdaIn));
  aci_i2c_receiver DUT (.sys_clk(sys_clk), .rst_n(rst_n), .sclClk(sclClk), .sdaIn(sdaIn), .sdaOutFf(sdaOutFf),
    .sdaOeFf(sdaOeFf), .busyFf(busyFf), .leftGainCodeFf(leftCode), .rightGainCodeFf(rightCode),
    .lowToneCodeFf(lowCode), .highToneCodeFf(highCode), .silenceFlagFf(silence), .effectEnableFf(effEn),
    .effectKindFf(effKind), .outputRouteHighFf(routeHi), .outputRouteLowFf(routeLo), .inputSourcePickFf(srcPick),
    .leftGainDbFf(), .leftFullAttFf(), .rightGainDbFf(), .rightFullAttFf(), .lowToneDbFf(), .highToneDbFf(),
    .inputPairTwoFf(), .routeModeFf(), .effectModeFf(), .pseudoOnFf());
  task automatic endSim();
    $display("checks %0d mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // only stored low bits are kept; selects 4 to 7 go nowhere
  function automatic void upd(input logic [7:0] s, input logic [7:0] b);
    if (s < 8'h02 || s == FSEL_SWITCH) mdl[s] = b & 8'h3F;
    else if (s < 8'h04) mdl[s] = b & 8'h0F;
  endfunction
  task automatic regsChk();
    chk("left", {2'h0, leftCode}, mdl[0]);
    chk("right", {2'h0, rightCode}, mdl[1]);
    chk("bass", {4'h0, lowCode}, mdl[2]);
    chk("treble", {4'h0, highCode}, mdl[3]);
    chk("switch", {2'h0, silence, effEn, effKind, routeHi, routeLo, srcPick}, mdl[8]);
  endtask
  task automatic xfer(input logic [7:0] sel, input logic [7:0] dq[$]);
    logic ack;
    logic [7:0] s;
    s = sel;
    M.startCond();
    M.sendByte({DEV_ADDR, 1'b0}, ack);
    chk("addr ack", {7'h0, ack}, 8'h01);
    chk("busy", {7'h0, busyFf}, 8'h01);
    M.sendByte(sel, ack);
    chk("select ack", {7'h0, ack}, 8'h01);
    foreach (dq[i]) begin
      M.sendByte(dq[i], ack);
      chk("data ack", {7'h0, ack}, 8'h01);
      upd(s, dq[i]);
      s = s + 8'h01;
    end
    M.stopCond();
    repeat (5) @(posedge sys_clk);
    chk("free", {7'h0, busyFf}, 8'h00);
    regsChk();
  endtask
  initial begin
    repeat (100000) @(posedge sys_clk);
    failures++;
    endSim();
  end
  initial begin
    logic ack;
    logic [7:0] s;
    logic [7:0] dq[$];
    void'($urandom(32'h699c));
    mdl = '{8'h00, 8'h00, 8'h06, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h26};
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    regsChk();
    $display("test reset done");
    // boundary codes, auto increment; switch word last by stepping 3..8
    xfer(FSEL_LEFT, '{8'hFF, 8'hDB, 8'hFF, 8'hF0});
    xfer(FSEL_HIGH, '{8'hF1, 8'hC0, 8'hC0, 8'hC0, 8'hC0, 8'hC7});
    xfer(FSEL_LEFT, '{8'hDC, 8'hC0, 8'hFB, 8'hFA});
    $display("test increment done");
    // every effect and route choice, mute set and released
    dq.delete();
    dq = '{8'hD8, 8'hD1, 8'hE6, 8'hC3, 8'hCC, 8'hE5};
    foreach (dq[i]) xfer(FSEL_SWITCH, '{dq[i]});
    $display("test switch done");
    // foreign address and read bit: no ack, nothing stored
    for (int i = 0; i < 2; i++) begin
      M.startCond();
      M.sendByte(i == 0 ? {DEV_ADDR ^ 7'h01, 1'b0} : {DEV_ADDR, 1'b1}, ack);
      chk("foreign ack", {7'h0, ack}, 8'h00);
      M.sendByte(FSEL_LEFT, ack);
      M.sendByte(8'hC5, ack);
      M.stopCond();
    end
    regsChk();
    $display("test foreign done");
    // byte cut by repeated start is dropped, the next transfer still lands
    M.startCond();
    M.sendByte({DEV_ADDR, 1'b0}, ack);
    M.sendByte(FSEL_LEFT, ack);
    M.bits(8'hC9, 5);
    xfer(FSEL_RIGHT, '{8'hE3});
    $display("test cut done");
    for (int n = 0; n < 6; n++) begin
      s = 8'($urandom_range(3, 0));
      dq.delete();
      for (int k = 0; k <= $urandom_range(3 - s, 0); k++) begin
        dq.push_back((s + k < 2) ? (8'hC0 | 8'($urandom_range(63, 0))) : (8'hF0 | 8'($urandom_range(15, 0))));
      end
      xfer(s, dq);
    end
    $display("test random done");
    endSim();
  end
endmodule
